// >>> rtl/drt_seq.sv
// Delta reversal trigger sequencer: registers, trigger handshake, two-phase math.
// Assumes conversions are done by an external converter via a start level and a done strobe.
//
// Contract
// - Output trigger after every delta conversion
// - Trigger, settle delay, convert phase one, pulse
// - Skip and ignore source's reversal trigger
// - Phase two done yields new delta reading
// - Delta is half difference minus relative offset
// - Line one outputs, line two inputs
// - Filter applied per phase, never mixed
// - Repeating filter forced to moving on entry
// - Two stacks, count samples each, averaged
// - Output trigger on each phase one conversion
// - Phase two conversion that fills its stack recomputes delta
// - Later measurements replace oldest sample
// - Filter config locked while delta enabled
// - Ratio and delta mutually exclusive
// - Delta refused under temperature functions
// - Reset: delta, ratio off; zero correction on
// - Zero correction off skips reference conversion
// - External trigger mode halts free running
// - Buffer stores each delta when enabled, up to BUF_N until the count is cleared
// - Re-entering external trigger returns to idle
`timescale 1ns/1ps
`default_nettype none
module drt_seq #(
  parameter int unsigned RDG_W   = drtseq_pkg::RDG_W,
  parameter int unsigned FDEPTH  = 15,
  parameter int unsigned BUF_N   = 8
) (
  input  wire logic                                CORE_CLK,
  input  wire logic                                RSTN,
  input  wire logic [drtseq_pkg::ADDR_W-1:0]       ADDR,
  input  wire logic [drtseq_pkg::DATA_W-1:0]       WDATA,
  input  wire logic                                WR,
  input  wire logic                                RD,
  output logic [drtseq_pkg::DATA_W-1:0]            RDATA,
  input  wire logic                                TRIG_LINE2_IN,
  output logic                                     TRIG_LINE1_OUT,
  output logic                                     CONV_START,
  output logic                                     CONV_ZERO_REF,
  input  wire logic                                CONV_DONE,
  input  wire logic signed [RDG_W-1:0]             CONV_DATA,
  output logic signed [RDG_W-1:0]                  DELTA_OUT,
  output logic                                     DELTA_VALID,
  output logic [RDG_W-1:0]                         BUF_WDATA,
  output logic                                     BUF_WE
);
  localparam int unsigned CW = drtseq_pkg::FILT_CNT_W;
  localparam int unsigned BW = $clog2(BUF_N + 1);

  logic [5:0]              ctrl_q;
  logic [1:0]              func_q;
  logic [7:0]              filt_q;
  logic [31:0]             delay_q;
  logic [15:0]             pulse_q;
  logic signed [RDG_W-1:0] rel_q;
  logic [BW-1:0]           bufcnt_q;
  logic [BW-1:0]           buflim_q;
  logic                    reject_q;

  logic                    trg_s1_q, trg_s2_q, trg_s3_q;
  logic                    trg_rise;
  drtseq_pkg::drt_state_e  st_q;
  logic [31:0]             wait_q;
  logic                    zref_q;
  logic                    conv_busy_q;
  logic                    ext_prev_q;
  logic                    fire;
  logic                    conv_main_done;
  logic                    push1, push2;
  logic                    full1, full2;
  logic signed [RDG_W-1:0] avg1, avg2;
  logic signed [RDG_W-1:0] ph1, ph2;
  logic signed [RDG_W:0]   diff;
  logic signed [RDG_W-1:0] delta_d;
  logic                    filt_on;
  logic                    restart;

  wire delta_on = ctrl_q[drtseq_pkg::CTRL_DELTA_BIT];
  wire ext_on   = ctrl_q[drtseq_pkg::CTRL_EXTTRIG_BIT];
  wire fzc_on   = ctrl_q[drtseq_pkg::CTRL_FZC_BIT];

  function automatic logic is_temp(input logic [1:0] f);
    is_temp = (f == drtseq_pkg::FUNC_TEMPERATURE_FUNCTION_ONE) || (f == drtseq_pkg::FUNC_TEMPERATURE_FUNCTION_TWO);
  endfunction

  function automatic logic wr_hit(input logic [3:0] a, input logic [3:0] ofs);
    wr_hit = (a == ofs);
  endfunction

  // Control register with mode interlocks
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      ctrl_q   <= drtseq_pkg::CTRL_RESET;
      reject_q <= 1'b0;
    end else if (WR && wr_hit(ADDR, drtseq_pkg::OFS_CTRL)) begin
      ctrl_q   <= WDATA[5:0];
      reject_q <= 1'b0;
      if (WDATA[drtseq_pkg::CTRL_DELTA_BIT] && !delta_on) begin
        if (is_temp(func_q)) begin
          ctrl_q[drtseq_pkg::CTRL_DELTA_BIT] <= 1'b0;
          reject_q                           <= 1'b1;
        end else begin
          ctrl_q[drtseq_pkg::CTRL_RATIO_BIT] <= 1'b0;
        end
      end else if (WDATA[drtseq_pkg::CTRL_RATIO_BIT] && !ctrl_q[drtseq_pkg::CTRL_RATIO_BIT]) begin
        ctrl_q[drtseq_pkg::CTRL_DELTA_BIT] <= 1'b0;
      end else if (WDATA[drtseq_pkg::CTRL_DELTA_BIT] && WDATA[drtseq_pkg::CTRL_RATIO_BIT]) begin
        ctrl_q[drtseq_pkg::CTRL_RATIO_BIT] <= 1'b0;
      end
    end else if (WR && wr_hit(ADDR, drtseq_pkg::OFS_FUNC) && is_temp(WDATA[1:0])) begin
      // Picking a temperature function ends delta
      ctrl_q[drtseq_pkg::CTRL_DELTA_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      func_q <= drtseq_pkg::FUNC_V1;
    end else if (WR && wr_hit(ADDR, drtseq_pkg::OFS_FUNC)) begin
      func_q <= WDATA[1:0];
    end else if (WR && wr_hit(ADDR, drtseq_pkg::OFS_CTRL) && WDATA[drtseq_pkg::CTRL_DELTA_BIT]
                 && func_q == drtseq_pkg::FUNC_V2) begin
      // Writing delta on while channel two is selected switches to channel one
      func_q <= drtseq_pkg::FUNC_V1;
    end
  end

  // Filter config: locked in delta, repeating forced to moving on entry
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      filt_q <= drtseq_pkg::FILT_RESET;
    end else if (WR && wr_hit(ADDR, drtseq_pkg::OFS_FILT) && !delta_on) begin
      filt_q <= WDATA[7:0];
    end else if (delta_on && filt_q[drtseq_pkg::FILT_RPT_BIT]) begin
      filt_q[drtseq_pkg::FILT_RPT_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      delay_q <= drtseq_pkg::DELAY_RESET;
      pulse_q <= drtseq_pkg::PULSE_RESET;
      rel_q   <= '0;
    end else if (WR) begin
      if (wr_hit(ADDR, drtseq_pkg::OFS_DELAY)) begin
        delay_q <= WDATA;
      end
      if (wr_hit(ADDR, drtseq_pkg::OFS_PULSE)) begin
        pulse_q <= WDATA[15:0];
      end
      if (wr_hit(ADDR, drtseq_pkg::OFS_REL)) begin
        rel_q <= RDG_W'(WDATA);
      end
    end
  end

  // Read port, data stands one cycle after the strobe
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      RDATA <= '0;
    end else if (RD) begin
      unique case (ADDR)
        drtseq_pkg::OFS_CTRL:   RDATA <= {26'h0, ctrl_q};
        drtseq_pkg::OFS_FUNC:   RDATA <= {30'h0, func_q};
        drtseq_pkg::OFS_FILT:   RDATA <= {24'h0, filt_q};
        drtseq_pkg::OFS_DELAY:  RDATA <= delay_q;
        drtseq_pkg::OFS_PULSE:  RDATA <= {16'h0, pulse_q};
        drtseq_pkg::OFS_REL:    RDATA <= 32'(rel_q);
        drtseq_pkg::OFS_STATUS: RDATA <= {24'h0, full2, full1, reject_q, 2'h0, 3'(st_q)};
        drtseq_pkg::OFS_RESULT: RDATA <= 32'(DELTA_OUT);
        drtseq_pkg::OFS_BUFCNT: RDATA <= 32'(bufcnt_q);
        default:                RDATA <= '0;
      endcase
    end else begin
      RDATA <= '0;
    end
  end

  // Input trigger: synchroniser then rising edge
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      trg_s1_q <= 1'b0;
      trg_s2_q <= 1'b0;
      trg_s3_q <= 1'b0;
    end else begin
      trg_s1_q <= TRIG_LINE2_IN;
      trg_s2_q <= trg_s1_q;
      trg_s3_q <= trg_s2_q;
    end
  end
  assign trg_rise = trg_s2_q && !trg_s3_q;

  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      ext_prev_q <= 1'b0;
    end else begin
      ext_prev_q <= ext_on;
    end
  end
  // Any change of trigger source or leaving delta restarts from idle
  assign restart = (ext_on != ext_prev_q) || !delta_on;

  // Free-running when not external; otherwise wait for the source
  wire go = ext_on ? trg_rise : 1'b1;

  assign conv_main_done = CONV_DONE && conv_busy_q && !zref_q;

  always_ff @(posedge CORE_CLK) begin
    if (!RSTN || restart) begin
      st_q        <= drtseq_pkg::DRT_IDLE;
      wait_q      <= '0;
      zref_q      <= 1'b0;
      conv_busy_q <= 1'b0;
    end else begin
      unique case (st_q)
        drtseq_pkg::DRT_IDLE: begin
          if (go) begin
            st_q   <= drtseq_pkg::DRT_SETTLE;
            wait_q <= delay_q;
          end
        end
        drtseq_pkg::DRT_SETTLE: begin
          if (wait_q != '0) begin
            wait_q <= wait_q - 32'h1;
          end else begin
            st_q        <= drtseq_pkg::DRT_CONV1;
            conv_busy_q <= 1'b1;
            zref_q      <= fzc_on;
          end
        end
        drtseq_pkg::DRT_CONV1, drtseq_pkg::DRT_CONV2: begin
          if (CONV_DONE && zref_q) begin
            zref_q <= 1'b0;
          end else if (conv_main_done) begin
            if (st_q == drtseq_pkg::DRT_CONV1 && (full1 || !filt_on)) begin
              // No wait for the source's returning trigger
              st_q   <= drtseq_pkg::DRT_CONV2;
              zref_q <= fzc_on;
            end else if (st_q == drtseq_pkg::DRT_CONV2 && (full2 || !filt_on)) begin
              st_q        <= drtseq_pkg::DRT_CALC;
              conv_busy_q <= 1'b0;
            end else begin
              zref_q <= fzc_on;
            end
          end
        end
        drtseq_pkg::DRT_CALC: begin
          st_q <= drtseq_pkg::DRT_IDLE;
        end
        default: begin
          st_q <= drtseq_pkg::DRT_IDLE;
        end
      endcase
    end
  end

  // Level request to converter; zero-reference qualifier alongside
  assign CONV_START    = conv_busy_q;
  assign CONV_ZERO_REF = zref_q;

  assign filt_on = filt_q[drtseq_pkg::FILT_EN_BIT];
  assign push1   = conv_main_done && st_q == drtseq_pkg::DRT_CONV1;
  assign push2   = conv_main_done && st_q == drtseq_pkg::DRT_CONV2;

  // Trigger edges during phase two are simply not looked at
  assign fire = conv_main_done;

  drt_pulse #(
    .W     (16)
  ) u_pulse (
    .clk   (CORE_CLK),
    .rst_n (RSTN),
    .fire  (fire),
    .width (pulse_q),
    .pulse (TRIG_LINE1_OUT)
  );

  drt_avg #(
    .DW     (RDG_W),
    .DEPTH  (FDEPTH),
    .CW     (CW)
  ) u_avg1 (
    .clk    (CORE_CLK),
    .rst_n  (RSTN),
    .clr    (restart),
    .push   (push1),
    .count  (filt_on ? filt_q[drtseq_pkg::FILT_CNT_LSB +: CW] : CW'(1)),
    .sample (CONV_DATA),
    .avg    (avg1),
    .full   (full1)
  );

  drt_avg #(
    .DW     (RDG_W),
    .DEPTH  (FDEPTH),
    .CW     (CW)
  ) u_avg2 (
    .clk    (CORE_CLK),
    .rst_n  (RSTN),
    .clr    (restart),
    .push   (push2),
    .count  (filt_on ? filt_q[drtseq_pkg::FILT_CNT_LSB +: CW] : CW'(1)),
    .sample (CONV_DATA),
    .avg    (avg2),
    .full   (full2)
  );

  assign ph1  = avg1;
  assign ph2  = avg2;
  assign diff = (RDG_W+1)'(ph1) - (RDG_W+1)'(ph2);
  // Arithmetic shift truncates toward minus infinity on odd differences
  assign delta_d = RDG_W'(diff >>> 1)
                 - (ctrl_q[drtseq_pkg::CTRL_REL_BIT] ? rel_q : '0);

  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      DELTA_OUT   <= '0;
      DELTA_VALID <= 1'b0;
    end else begin
      DELTA_VALID <= 1'b0;
      if (st_q == drtseq_pkg::DRT_CALC) begin
        DELTA_OUT   <= delta_d;
        DELTA_VALID <= 1'b1;
      end
    end
  end

  // Reading buffer write port
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      BUF_WE    <= 1'b0;
      BUF_WDATA <= '0;
      bufcnt_q  <= '0;
      buflim_q  <= BW'(BUF_N);
    end else begin
      BUF_WE <= 1'b0;
      if (WR && wr_hit(ADDR, drtseq_pkg::OFS_BUFCNT)) begin
        bufcnt_q <= '0;
      end else if (st_q == drtseq_pkg::DRT_CALC && ctrl_q[drtseq_pkg::CTRL_BUF_BIT]
                   && bufcnt_q < buflim_q) begin
        BUF_WE    <= 1'b1;
        BUF_WDATA <= delta_d;
        bufcnt_q  <= bufcnt_q + BW'(1);
      end
    end
  end
endmodule
`default_nettype wire

// >>> rtl/drtseq_pkg.sv
// Package for the delta reversal trigger sequencer: register map, fields, timing.
// Assumes a 20 MHz core clock and a plain strobe register port.
package drtseq_pkg;

  localparam int unsigned CLK_HZ            = 20000000;
  localparam int unsigned ADDR_W            = 4;
  localparam int unsigned DATA_W            = 32;
  localparam int unsigned RDG_W             = 24;

  // Register offsets (word index)
  localparam logic [3:0] OFS_CTRL           = 4'h0;
  localparam logic [3:0] OFS_FUNC           = 4'h1;
  localparam logic [3:0] OFS_FILT           = 4'h2;
  localparam logic [3:0] OFS_DELAY          = 4'h3;
  localparam logic [3:0] OFS_PULSE          = 4'h4;
  localparam logic [3:0] OFS_REL            = 4'h5;
  localparam logic [3:0] OFS_STATUS         = 4'h6;
  localparam logic [3:0] OFS_RESULT         = 4'h7;
  localparam logic [3:0] OFS_BUFCNT         = 4'h8;

  // CTRL fields
  localparam int unsigned CTRL_DELTA_BIT    = 0;
  localparam int unsigned CTRL_RATIO_BIT    = 1;
  localparam int unsigned CTRL_FZC_BIT      = 2;
  localparam int unsigned CTRL_EXTTRIG_BIT  = 3;
  localparam int unsigned CTRL_REL_BIT      = 4;
  localparam int unsigned CTRL_BUF_BIT      = 5;
  localparam logic [5:0]  CTRL_RESET        = 6'h04;

  // FUNC codes
  localparam logic [1:0] FUNC_V1            = 2'h0;
  localparam logic [1:0] FUNC_V2            = 2'h1;
  localparam logic [1:0] FUNC_TEMPERATURE_FUNCTION_ONE         = 2'h2;
  localparam logic [1:0] FUNC_TEMPERATURE_FUNCTION_TWO         = 2'h3;

  // FILT fields: bit0 enable, bit1 type (1 = repeating), bits 7:4 count
  localparam int unsigned FILT_EN_BIT       = 0;
  localparam int unsigned FILT_RPT_BIT      = 1;
  localparam int unsigned FILT_CNT_LSB      = 4;
  localparam int unsigned FILT_CNT_W        = 4;
  localparam logic [7:0]  FILT_RESET        = 8'h50;

  // Timing: pulse width in ns, converted to cycles (round up)
  localparam int unsigned PULSE_NS          = 10000;
  localparam int unsigned PULSE_CYC         = (PULSE_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam logic [15:0] PULSE_RESET       = 16'(PULSE_CYC);
  localparam logic [31:0] DELAY_RESET       = 32'h0000_0000;

  typedef enum logic [2:0] {
    DRT_IDLE, DRT_SETTLE, DRT_CONV1, DRT_CONV2, DRT_CALC
  } drt_state_e;

endpackage

// >>> rtl/drt_pulse.sv
// Fixed-width output trigger pulse generator.
// Assumes fire is a one-cycle request; a new request restarts the pulse.
`timescale 1ns/1ps
`default_nettype none
module drt_pulse #(
  parameter int unsigned W = 16
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         fire,
  input  wire logic [W-1:0] width,
  output logic              pulse
);
  logic [W-1:0] cnt_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (fire) begin
      cnt_q <= (width == '0) ? W'(1) : width;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - W'(1);
    end
  end

  assign pulse = (cnt_q != '0);
endmodule
`default_nettype wire

// >>> rtl/drt_avg.sv
// Moving-average stack for one measurement phase, flip-flop storage.
// Assumes clr empties the stack; push adds one sample, dropping the oldest once the stack is full.
`timescale 1ns/1ps
`default_nettype none
module drt_avg #(
  parameter int unsigned DW    = 24,
  parameter int unsigned DEPTH = 15,
  parameter int unsigned CW    = 4
) (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 clr,
  input  wire logic                 push,
  input  wire logic [CW-1:0]        count,
  input  wire logic signed [DW-1:0] sample,
  output logic signed [DW-1:0]      avg,
  output logic                      full
);
  logic signed [DW-1:0]  mem_q [DEPTH];
  logic [CW-1:0]         wp_q;
  logic [CW-1:0]         fill_q;
  logic signed [DW+CW:0] sum;
  logic [CW-1:0]         n;

  assign n = (count == '0) ? CW'(1) : count;

  always_ff @(posedge clk) begin
    if (!rst_n || clr) begin
      wp_q   <= '0;
      fill_q <= '0;
    end else if (push) begin
      mem_q[wp_q] <= sample;
      wp_q        <= (wp_q + CW'(1) >= n) ? '0 : wp_q + CW'(1);
      if (fill_q < n) begin
        fill_q <= fill_q + CW'(1);
      end
    end
  end

  always_comb begin
    sum = '0;
    for (int i = 0; i < DEPTH; i++) begin
      if (CW'(i) < fill_q) begin
        sum = sum + (DW+CW+1)'(mem_q[i]);
      end
    end
  end

  // Counts the sample being pushed, so a phase ends on its last conversion
  assign full = (fill_q >= n) || (push && (fill_q + CW'(1) >= n));
  assign avg  = (fill_q == '0) ? '0 : DW'(sum / $signed({1'b0, fill_q}));
endmodule
`default_nettype wire

// >>> test/drtseq_chk.sv
// Checker for the delta reversal trigger sequencer top-level ports.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module drtseq_chk #(
  parameter int unsigned RDG_W = 24
) (
  input wire logic                    CORE_CLK,
  input wire logic                    RSTN,
  input wire logic [3:0]              ADDR,
  input wire logic [31:0]             WDATA,
  input wire logic                    WR,
  input wire logic                    RD,
  input wire logic [31:0]             RDATA,
  input wire logic                    TRIG_LINE1_OUT,
  input wire logic                    CONV_ZERO_REF,
  input wire logic                    CONV_DONE,
  input wire logic signed [RDG_W-1:0] DELTA_OUT,
  input wire logic                    DELTA_VALID,
  input wire logic [RDG_W-1:0]        BUF_WDATA,
  input wire logic                    BUF_WE
);
  logic [15:0] pw_q;
  logic [15:0] hi_q;
  logic [15:0] pw_eff;

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);

  // Shadow of the pulse width register; a zero width still gives one cycle
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) pw_q <= drtseq_pkg::PULSE_RESET;
    else if (WR && ADDR == drtseq_pkg::OFS_PULSE) pw_q <= WDATA[15:0];
  end
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) hi_q <= '0;
    else hi_q <= TRIG_LINE1_OUT ? hi_q + 16'h1 : 16'h0;
  end
  always_comb pw_eff = (pw_q == 16'h0) ? 16'h1 : pw_q;

  a_trig_after_conv: assert property (CONV_DONE && !CONV_ZERO_REF |=> TRIG_LINE1_OUT)
    else $error("output trigger missing after conversion");
  a_trig_has_cause: assert property ($rose(TRIG_LINE1_OUT) |->
    $past(CONV_DONE) && !$past(CONV_ZERO_REF))
    else $error("output trigger without a measuring conversion");
  a_pulse_width: assert property ($fell(TRIG_LINE1_OUT) |-> hi_q == pw_eff)
    else $error("output trigger width wrong");
  a_valid_single: assert property (DELTA_VALID |=> !DELTA_VALID)
    else $error("result strobe longer than one cycle");
  a_valid_cause: assert property (DELTA_VALID |->
    $past(CONV_DONE, 2) && !$past(CONV_ZERO_REF, 2))
    else $error("result strobe without a conversion two cycles before");
  a_buf_copy: assert property (BUF_WE |->
    DELTA_VALID && BUF_WDATA == $unsigned(DELTA_OUT))
    else $error("buffer store differs from result");
  a_delta_hold: assert property (!DELTA_VALID |-> $stable(DELTA_OUT))
    else $error("result changed without strobe");
  a_rdata_idle: assert property (!$past(RD) |-> RDATA == 32'h0)
    else $error("read data not zero outside read answer");
  a_unmapped_zero: assert property (RD && ADDR > drtseq_pkg::OFS_BUFCNT |=> RDATA == 32'h0)
    else $error("unmapped read not zero");

  c_buffered: cover property (DELTA_VALID && BUF_WE);
  c_zero_ref: cover property (CONV_DONE && CONV_ZERO_REF);
  c_pulse_end: cover property ($fell(TRIG_LINE1_OUT));
endmodule

bind drt_seq drtseq_chk #(.RDG_W(RDG_W)) u_chk (.CORE_CLK, .RSTN, .ADDR, .WDATA, .WR, .RD, .RDATA,
  .TRIG_LINE1_OUT, .CONV_ZERO_REF, .CONV_DONE, .DELTA_OUT, .DELTA_VALID, .BUF_WDATA, .BUF_WE);
`default_nettype wire

// >>> test/drtseq_src_model.sv
// Bipolar current source with trigger handshake, plus the converter it feeds.
// Assumes go is a one-cycle start of a two-point sweep; samples depend on polarity.
`timescale 1ns/1ps
`default_nettype none
module drtseq_src_model #(
  parameter int LAT  = 6,
  parameter int RESP = 2
) (
  input wire logic               clk,
  input wire logic               rst_n,
  input wire logic               go,
  input wire logic               en,
  input wire logic               trig_in,
  output logic                   trig_out,
  input wire logic               conv_start,
  input wire logic               zero_ref,
  output logic                   conv_done,
  output logic signed [23:0]     conv_data,
  input wire logic signed [23:0] pos_v,
  input wire logic signed [23:0] neg_v
);
  logic pol;
  logic tin_d;
  int   left;
  int   dly;
  int   ccnt;

  // Point applied the moment the trigger lands; only the fixed wire latency follows
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pol <= 1'b1;
      left <= 0;
      dly <= 0;
      tin_d <= 1'b0;
      trig_out <= 1'b0;
    end else begin
      tin_d <= trig_in;
      trig_out <= (dly == 1);
      if (go) begin
        pol <= 1'b1;
        left <= 1;
        dly <= RESP;
      end else if (trig_in && !tin_d && left > 0) begin
        pol <= ~pol;
        left <= left - 1;
        dly <= RESP;
      end else if (dly > 0) begin
        dly <= dly - 1;
      end
    end
  end

  // Data line is not held between conversions
  always_ff @(posedge clk) begin
    if (!rst_n || !en || !conv_start) begin
      ccnt <= 0;
      conv_done <= 1'b0;
      conv_data <= ~conv_data;
    end else begin
      conv_done <= (ccnt == 1);
      ccnt <= (ccnt == 0) ? LAT : ccnt - 1;
      if (ccnt == 1) conv_data <= zero_ref ? 24'h7a5c3e : (pol ? pos_v : neg_v);
      else conv_data <= ~conv_data;
    end
  end
endmodule
`default_nettype wire

// >>> test/drt_seq_tb.sv
// Self-checking bench for the delta reversal trigger sequencer.
// Assumes the source model above; expectations come from a moving-average model here.
`timescale 1ns/1ps
`default_nettype none
module drt_seq_tb;
  logic               clk, rst_n, wr, rd, trg_in, trg_out, cst, zref, cdone;
  logic               dvalid, bwe, src_go, cnv_en, t_d;
  logic [3:0]         addr;
  logic [31:0]        wdata, rdata, rv;
  logic signed [23:0] cdata, dout, pos_v, neg_v, rel;
  logic [23:0]        bwdata;
  logic               relon;
  int                 errors, n_checks, seed, cyc, k, per, n_filt, pulses, dones, got, bufs;
  logic signed [23:0] q1[$];
  logic signed [23:0] q2[$];

  drt_seq dut (.CORE_CLK(clk), .RSTN(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .TRIG_LINE2_IN(trg_in), .TRIG_LINE1_OUT(trg_out), .CONV_START(cst),
    .CONV_ZERO_REF(zref), .CONV_DONE(cdone), .CONV_DATA(cdata), .DELTA_OUT(dout),
    .DELTA_VALID(dvalid), .BUF_WDATA(bwdata), .BUF_WE(bwe));
  drtseq_src_model src (.clk(clk), .rst_n(rst_n), .go(src_go), .en(cnv_en), .trig_in(trg_out),
    .trig_out(trg_in), .conv_start(cst), .zero_ref(zref), .conv_done(cdone), .conv_data(cdata),
    .pos_v(pos_v), .neg_v(neg_v));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask

  function automatic logic [23:0] exp_delta();
    int s1, s2;
    s1 = 0;
    s2 = 0;
    foreach (q1[i]) s1 += q1[i];
    foreach (q2[i]) s2 += q2[i];
    return 24'((((s1 / n_filt) - (s2 / n_filt)) >>> 1) - (relon ? int'(rel) : 0));
  endfunction

  // Restart the stack model, as entering delta or toggling the trigger mode does
  task automatic enter(input int n);
    n_filt = n;
    per = n;
    k = 0;
    q1.delete();
    q2.delete();
  endtask

  // Stacks per phase; the first measurement fills each with the filter count
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      print_verdict();
    end
    t_d <= trg_out;
    if (trg_out && !t_d) pulses++;
    if (cdone) dones++;
    if (bwe) bufs++;
    if (cdone && !zref) begin
      if (k < per) q1.push_back(cdata);
      else q2.push_back(cdata);
      k++;
      if (q1.size() > n_filt) void'(q1.pop_front());
      if (q2.size() > n_filt) void'(q2.pop_front());
    end
    if (dvalid) begin
      check({8'h0, dout}, {8'h0, exp_delta()});
      k = 0;
      per = 1;
      got++;
    end
  end

  task automatic measure(input int np, input int nd, input int nb, input logic [23:0] msk);
    int t;
    pos_v <= (24'($random(seed)) & msk) - 24'h200000;
    neg_v <= (24'($random(seed)) & msk) - 24'h200000;
    cnv_en <= 1'b1;
    dones = 0;
    pulses = 0;
    got = 0;
    bufs = 0;
    repeat (20) @(posedge clk);
    check(32'(dones), 32'h0);
    src_go <= 1'b1;
    @(posedge clk);
    src_go <= 1'b0;
    for (t = 0; t < 3000 && got == 0; t++) @(posedge clk);
    repeat (80) @(posedge clk);
    check(32'(got), 32'h1);
    check(32'(pulses), 32'(np));
    check(32'(dones), 32'(nd));
    check(32'(bufs), 32'(nb));
    cnv_en <= 1'b0;
  endtask

  initial begin
    seed = 90583;
    rst_n = 1'b0;
    {wr, rd, src_go, cnv_en, relon} = '0;
    addr = 4'h0;
    wdata = 32'h0;
    {pos_v, neg_v, rel} = '0;
    {errors, n_checks, cyc, pulses, dones, got, bufs} = '0;
    enter(1);
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(drtseq_pkg::OFS_CTRL, rv);
    check(rv, 32'(drtseq_pkg::CTRL_RESET));
    rd_reg(drtseq_pkg::OFS_FILT, rv);
    check(rv, 32'(drtseq_pkg::FILT_RESET));
    rd_reg(4'hc, rv);
    check(rv, 32'h0);
    for (int i = 32'(drtseq_pkg::FUNC_TEMPERATURE_FUNCTION_ONE); i <= 32'(drtseq_pkg::FUNC_TEMPERATURE_FUNCTION_TWO); i++) begin
      wr_reg(drtseq_pkg::OFS_FUNC, 32'(i));
      wr_reg(drtseq_pkg::OFS_CTRL, 32'h05);
      rd_reg(drtseq_pkg::OFS_CTRL, rv);
      check({31'h0, rv[0]}, 32'h0);
    end
    wr_reg(drtseq_pkg::OFS_FUNC, 32'(drtseq_pkg::FUNC_V1));
    wr_reg(drtseq_pkg::OFS_CTRL, 32'h06);
    wr_reg(drtseq_pkg::OFS_CTRL, 32'h07);
    rd_reg(drtseq_pkg::OFS_CTRL, rv);
    check(rv, 32'h05);
    wr_reg(drtseq_pkg::OFS_CTRL, 32'h07);
    rd_reg(drtseq_pkg::OFS_CTRL, rv);
    check(rv, 32'h06);
    wr_reg(drtseq_pkg::OFS_CTRL, 32'h04);
    wr_reg(drtseq_pkg::OFS_FILT, 32'h23);
    wr_reg(drtseq_pkg::OFS_CTRL, 32'h05);
    rd_reg(drtseq_pkg::OFS_FILT, rv);
    check(rv, 32'h21);
    wr_reg(drtseq_pkg::OFS_FILT, 32'h50);
    rd_reg(drtseq_pkg::OFS_FILT, rv);
    check(rv, 32'h21);
    // Unfiltered: every zero-correction and offset combination, buffer on
    wr_reg(drtseq_pkg::OFS_CTRL, 32'h00);
    wr_reg(drtseq_pkg::OFS_FILT, 32'h20);
    wr_reg(drtseq_pkg::OFS_PULSE, 32'h3);
    for (int i = 0; i < 4; i++) begin
      relon = i[1];
      rel = 24'($random(seed)) & 24'h00ffff;
      wr_reg(drtseq_pkg::OFS_REL, 32'(rel));
      wr_reg(drtseq_pkg::OFS_DELAY, 32'($random(seed)) & 32'h7);
      wr_reg(drtseq_pkg::OFS_CTRL, 32'h00);
      enter(1);
      wr_reg(drtseq_pkg::OFS_CTRL, {26'h0, 1'b1, relon, 1'b1, i[0], 2'b01});
      measure(2, 2 * (1 + i[0]), 1, 24'h3fffff);
    end
    // Moving filter of two: fill, then one new sample per stack
    relon = 1'b0;
    wr_reg(drtseq_pkg::OFS_CTRL, 32'h00);
    wr_reg(drtseq_pkg::OFS_FILT, 32'h21);
    enter(2);
    wr_reg(drtseq_pkg::OFS_CTRL, 32'h09);
    measure(4, 4, 0, 24'h3ffffe);
    measure(2, 2, 0, 24'h3ffffe);
    wr_reg(drtseq_pkg::OFS_CTRL, 32'h01);
    wr_reg(drtseq_pkg::OFS_CTRL, 32'h09);
    enter(2);
    rd_reg(drtseq_pkg::OFS_STATUS, rv);
    check({29'h0, rv[2:0]}, {29'h0, drtseq_pkg::DRT_IDLE});
    measure(4, 4, 0, 24'h3ffffe);
    print_verdict();
  end
endmodule
`default_nettype wire
